// ==== design/dsc_alu_instr_subset_decode.sv ====
// Instruction subset decoder and executor with an AXI4-Lite register port
//
// Operation
// - square pairs only W4..W7 with themselves
// - multiply pairs six distinct picks from W4..W7
// - file-form default work register is W0
// - register field selects any of sixteen
// - X prefetch via W8/W9, modify, index, none
// - X prefetch lands in W4..W7
// - Y prefetch via W10/W11, modify, index, none
// - Y prefetch lands in W4..W7
// - signed short literal accumulator add, DSP flags
// - 10-bit literal sum with carry, five flags
// - short literal sum with carry to destination
// - file form sum with carry into W0 or the file
// - one-bit shift updates C, N, OV, Z
// - multi-bit shift updates only N, Z
// - multi-bit shift by 5-bit literal, one cycle
// - signed GE jump, 1 or 2 cycles
// - unsigned GE jump on carry, flags kept
// - 24-bit word, top eight bits opcode
// - taken jump adds one no-operation cycle
//
// Our own choices: the AXI4-Lite register port and the address map.
module dsc_alu_instr_subset_decode
  import dsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [15:0] default_work_reg_zero [16]; // Working registers
  logic [15:0] dmem [16]; // Data words, also the file registers
  logic [15:0] next_default_work_reg_zero [16];
  logic [15:0] next_dmem [16];
  flags_t flags, next_flags; // Status word
  logic [15:0] pc, next_pc; // Program counter in words
  logic [39:0] acc_a, acc_b, next_acc_a, next_acc_b; // Accumulators
  logic [23:0] instr, next_instr; // Instruction being executed
  fsm_t state, next_state; // Sequencer
  logic [1:0] last_cyc, next_last_cyc; // Cycles of last instruction
  logic illegal, next_illegal; // Last opcode or multiplier pair field was illegal
  // Bus holding registers
  logic [7:0] awaddr, next_awaddr;
  logic aw_full, next_aw_full;
  logic [31:0] wdata, next_wdata;
  logic [3:0] wstrb, next_wstrb;
  logic w_full, next_w_full;
  logic next_bvalid, next_rvalid, next_arready;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wr_fire; // Buffered write commits this cycle

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Byte-lane merge of a bus write into a 16-bit word
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // Saturating 40-bit accumulate: {saturated, overflowed, result}
  function automatic logic [41:0] acc_add(input logic [39:0] a, input logic [39:0] b);
    logic [40:0] s;
    logic [39:0] r;
    s = {a[39], a} + {b[39], b};
    r = s[39:0];
    if (s[40] != s[39])
    begin
      r = s[40] ? ACC_MIN : ACC_MAX;
    end
    acc_add = {s[40] != s[39], ~((&r[39:31]) | ~(|r[39:31])), r};
  endfunction : acc_add

  // Prefetch decode: {active, uses second pointer, indexed, signed step}
  function automatic logic [6:0] pf_dec(input logic [3:0] code);
    logic [2:0] k;
    logic [3:0] step;
    k = (code >= PF_SECOND) ? 3'(code - PF_SECOND) : code[2:0];
    step = 4'h0;
    if (k >= 3'h4)
    begin
      step = 4'(-(2 * (k - 3'h3)));
    end
    else
    begin
      step = 4'(2 * k);
    end
    pf_dec = {code != PF_NONE, code >= PF_SECOND, code == PF_IDX, step};
  endfunction : pf_dec

  ////////////////////////////////////////////////////////////////////////////
  // Decoded operands
  // opcode from top byte
  logic [7:0] opc;
  logic [3:0] wb_i, wd_i, ws_i, f_i;
  logic [15:0] wb_v, ws_v, f_v, w0_v;
  assign opc = instr[23:OPC_LSB];
  assign wb_i = instr[WB_LSB+:4];
  assign wd_i = instr[WD_LSB+:4];
  assign ws_i = instr[3:0];
  assign f_i = instr[4:1];
  assign wb_v = default_work_reg_zero[wb_i];
  assign ws_v = default_work_reg_zero[ws_i];
  assign f_v = dmem[f_i];
  assign w0_v = default_work_reg_zero[W_ZERO];

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic datapath
  logic [15:0] add_a, add_b, add_r, sh_src, sh_r;
  logic [16:0] add_s;
  logic [4:0] nib_s, sh_cnt;
  logic [3:0] mul_m, mul_n;
  logic mul_ok;
  logic [31:0] prod;
  // Operand selection for the sum-with-carry and shift forms
  always_comb
  begin
    add_a = wb_v;
    add_b = 16'(instr[4:0]);
    sh_src = wb_v;
    sh_cnt = instr[4:0];
    unique case (opc)
      OP_SUM_WITH_CARRY_OP_F:
      begin
        add_a = f_v;
        add_b = w0_v;
      end
      OP_SUM_WITH_CARRY_OP_L10:
      begin
        add_a = ws_v;
        add_b = 16'(instr[13:4]);
      end
      OP_SUM_WITH_CARRY_OP_W: add_b = ws_v;
      OP_ASR_F:
      begin
        sh_src = f_v;
        sh_cnt = 5'h01;
      end
      OP_ASR_W:
      begin
        sh_src = ws_v;
        sh_cnt = 5'h01;
      end
      OP_ASR_WW: sh_cnt = {1'b0, ws_v[3:0]};
      default: ;
    endcase
  end
  assign add_s = {1'b0, add_a} + {1'b0, add_b} + {16'h0000, flags.c};
  assign nib_s = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, flags.c};
  assign add_r = add_s[15:0];
  assign sh_r = 16'($signed(sh_src) >>> sh_cnt);

  // Multiplier pair decode, six distinct pairs or a square
  always_comb
  begin
    mul_ok = 1'b1;
    mul_m = W_MUL0;
    mul_n = W_MUL0;
    if (opc == OP_SQR)
    begin
      mul_m = W_MUL0 + {2'h0, instr[MUL_LSB+:2]};
      mul_n = mul_m;
    end
    else
    begin
      unique case (instr[MUL_LSB+:3])
        3'h0: mul_n = 4'h5;
        3'h1: mul_n = 4'h6;
        3'h2: mul_n = 4'h7;
        3'h3: {mul_m, mul_n} = 8'h56;
        3'h4: {mul_m, mul_n} = 8'h57;
        3'h5: {mul_m, mul_n} = 8'h67;
        default: mul_ok = 1'b0;
      endcase
    end
  end
  // Widen both factors first so the product keeps all 32 bits
  assign prod = 32'($signed(default_work_reg_zero[mul_m])) * 32'($signed(default_work_reg_zero[mul_n]));

  ////////////////////////////////////////////////////////////////////////////
  // Execution next state
  logic [6:0] xpf, ypf;
  logic [3:0] xp_i, yp_i;
  logic [15:0] xaddr, yaddr;
  logic [41:0] acc_r;
  logic [39:0] acc_in, addend;
  logic taken;
  assign xpf = pf_dec(instr[XPF_LSB+:4]);
  assign ypf = pf_dec(instr[YPF_LSB+:4]);
  // X pointer W8 or W9, indexed W9 plus W12
  assign xp_i = xpf[5] ? W_X1 : W_X0;
  assign xaddr = xpf[4] ? default_work_reg_zero[W_X1] + default_work_reg_zero[W_IDX] : default_work_reg_zero[xp_i];
  // Y pointer W10 or W11, indexed W11 plus W12
  assign yp_i = ypf[5] ? W_Y1 : W_Y0;
  assign yaddr = ypf[4] ? default_work_reg_zero[W_Y1] + default_work_reg_zero[W_IDX] : default_work_reg_zero[yp_i];
  assign acc_in = instr[ACC_BIT] ? acc_b : acc_a;
  assign addend = (opc == OP_ADD_SLIT) ?
                  40'($signed(ws_v)) + 40'($signed(instr[WD_LSB+:4])) :
                  40'($signed(prod));
  assign acc_r = acc_add(acc_in, addend);
  // signed GE when N equals OV
  assign taken = (opc == OP_BRA_GE) ? (flags.n == flags.ov) :
                 ((opc == OP_BRA_GEU) || (opc == OP_BRA_C)) && flags.c;

  // Instruction execution, bus writes and the sequencer
  always_comb
  begin
    next_default_work_reg_zero = default_work_reg_zero;
    next_dmem = dmem;
    next_flags = flags;
    next_pc = pc;
    next_acc_a = acc_a;
    next_acc_b = acc_b;
    next_instr = instr;
    next_state = state;
    next_last_cyc = last_cyc;
    next_illegal = illegal;
    unique case (state)
      ST_IDLE:
      begin
        if (wr_fire)
        begin
          // Register writes land only between instructions
          unique case (awaddr[7:6])
            RGN_DEFAULT_WORK_REG_ZERO: next_default_work_reg_zero[awaddr[5:2]] = merge16(default_work_reg_zero[awaddr[5:2]], wdata, wstrb);
            RGN_DMEM: next_dmem[awaddr[5:2]] = merge16(dmem[awaddr[5:2]], wdata, wstrb);
            default:
            begin
              if (awaddr == OFS_INSTR)
              begin
                next_instr = wdata[23:0];
                next_state = ST_EXEC;
              end
              else if (awaddr == OFS_STATUS)
              begin
                next_flags = flags_t'(wdata[8:0]);
              end
              else if (awaddr == OFS_PC)
              begin
                next_pc = merge16(pc, wdata, wstrb);
              end
            end
          endcase
        end
      end
      ST_EXEC:
      begin
        next_pc = pc + 16'h0001;
        next_last_cyc = CYC_ONE;
        next_illegal = 1'b0;
        next_state = ST_IDLE;
        unique case (opc)
          OP_SUM_WITH_CARRY_OP_F, OP_SUM_WITH_CARRY_OP_L10, OP_SUM_WITH_CARRY_OP_W, OP_SUM_WITH_CARRY_OP_L5:
          begin
            // file form writes W0 or the file
            if (opc == OP_SUM_WITH_CARRY_OP_F && !instr[D_BIT])
              next_default_work_reg_zero[W_ZERO] = add_r;
            else if (opc == OP_SUM_WITH_CARRY_OP_F)
              next_dmem[f_i] = add_r;
            else if (opc == OP_SUM_WITH_CARRY_OP_L10)
              next_default_work_reg_zero[ws_i] = add_r;
            else
              next_default_work_reg_zero[wd_i] = add_r;
            // C, DC, N, OV, sticky Z
            next_flags.c = add_s[16];
            next_flags.dc = nib_s[4];
            next_flags.n = add_r[15];
            next_flags.ov = (add_a[15] == add_b[15]) && (add_r[15] != add_a[15]);
            next_flags.z = flags.z && (add_r == 16'h0000);
          end
          OP_ASR_F, OP_ASR_W:
          begin
            if (opc == OP_ASR_W)
              next_default_work_reg_zero[wd_i] = sh_r;
            else if (instr[D_BIT])
              next_dmem[f_i] = sh_r;
            else
              next_default_work_reg_zero[W_ZERO] = sh_r;
            next_flags.c = sh_src[0];
            next_flags.n = sh_r[15];
            next_flags.ov = 1'b0;
            next_flags.z = (sh_r == 16'h0000);
          end
          OP_ASR_WW, OP_ASR_L5:
          begin
            next_default_work_reg_zero[wd_i] = sh_r;
            next_flags.n = sh_r[15];
            next_flags.z = (sh_r == 16'h0000);
          end
          OP_BRA_C, OP_BRA_GE, OP_BRA_GEU:
          begin
            // taken jump spends a no-operation cycle
            if (taken)
            begin
              next_pc = pc + 16'h0001 + instr[15:0];
              next_last_cyc = CYC_TWO;
              next_state = ST_NOP;
            end
          end
          OP_ADD_SLIT, OP_MAC, OP_SQR:
          begin
            if (opc == OP_MAC && !mul_ok)
            begin
              next_illegal = 1'b1;
            end
            else
            begin
              // accumulator and its overflow, saturation flags
              if (instr[ACC_BIT])
              begin
                next_acc_b = acc_r[39:0];
                next_flags.ob = acc_r[40];
                next_flags.sb = flags.sb | acc_r[41];
              end
              else
              begin
                next_acc_a = acc_r[39:0];
                next_flags.oa = acc_r[40];
                next_flags.sa = flags.sa | acc_r[41];
              end
              if (opc != OP_ADD_SLIT)
              begin
                if (xpf[6] && !xpf[4])
                  next_default_work_reg_zero[xp_i] = default_work_reg_zero[xp_i] + {{12{xpf[3]}}, xpf[3:0]};
                if (ypf[6] && !ypf[4])
                  next_default_work_reg_zero[yp_i] = default_work_reg_zero[yp_i] + {{12{ypf[3]}}, ypf[3:0]};
                if (xpf[6])
                  next_default_work_reg_zero[W_MUL0 + {2'h0, instr[XD_LSB+:2]}] = dmem[xaddr[4:1]];
                if (ypf[6])
                  next_default_work_reg_zero[W_MUL0 + {2'h0, instr[1:0]}] = dmem[yaddr[4:1]];
              end
            end
          end
          default: next_illegal = 1'b1;
        endcase
      end
      ST_NOP: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Core registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 16; i++)
      begin
        default_work_reg_zero[i] <= 16'h0000;
        dmem[i] <= 16'h0000;
      end
      flags <= '0;
      pc <= PC_RESET;
      acc_a <= 40'h0000000000;
      acc_b <= 40'h0000000000;
      instr <= 24'h000000;
      state <= ST_IDLE;
      last_cyc <= 2'h0;
      illegal <= 1'b0;
    end
    else if (ce)
    begin
      default_work_reg_zero <= next_default_work_reg_zero;
      dmem <= next_dmem;
      flags <= next_flags;
      pc <= next_pc;
      acc_a <= next_acc_a;
      acc_b <= next_acc_b;
      instr <= next_instr;
      state <= next_state;
      last_cyc <= next_last_cyc;
      illegal <= next_illegal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic wr_ok, rd_ok;
  logic [31:0] rd_mux;
  assign wr_ok = (awaddr[7:6] != RGN_MISC) || (awaddr <= OFS_PC);
  assign wr_fire = aw_full && w_full && !s_axi_bvalid && (state == ST_IDLE);
  // Read data selection
  always_comb
  begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr[7:6])
      RGN_DEFAULT_WORK_REG_ZERO: rd_mux = {16'h0000, default_work_reg_zero[s_axi_araddr[5:2]]};
      RGN_DMEM: rd_mux = {16'h0000, dmem[s_axi_araddr[5:2]]};
      RGN_MISC:
      begin
        unique case (s_axi_araddr)
          OFS_INSTR: rd_mux = {8'h00, instr};
          OFS_STATUS: rd_mux = {23'h000000, flags};
          OFS_PC: rd_mux = {16'h0000, pc};
          OFS_EXINFO: rd_mux = {28'h0000000, illegal, state != ST_IDLE, last_cyc};
          OFS_ACCA_LO: rd_mux = acc_a[31:0];
          OFS_ACCA_HI: rd_mux = {24'h000000, acc_a[39:32]};
          OFS_ACCB_LO: rd_mux = acc_b[31:0];
          OFS_ACCB_HI: rd_mux = {24'h000000, acc_b[39:32]};
          default: rd_ok = 1'b0;
        endcase
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // Channel handshakes
  always_comb
  begin
    next_awaddr = awaddr;
    next_aw_full = aw_full;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_w_full = w_full;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_arready = s_axi_arready;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_awaddr = {s_axi_awaddr[7:2], 2'h0};
      next_aw_full = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_wdata = s_axi_wdata;
      next_wstrb = s_axi_wstrb;
      next_w_full = 1'b1;
    end
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (wr_fire)
    begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_arready = 1'b0;
      next_rdata = rd_mux;
      next_rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Bus registers; every output comes from here
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awaddr <= 8'h00;
      aw_full <= 1'b0;
      wdata <= 32'h00000000;
      wstrb <= 4'h0;
      w_full <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ce)
    begin
      awaddr <= next_awaddr;
      aw_full <= next_aw_full;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      w_full <= next_w_full;
      s_axi_awready <= !next_aw_full;
      s_axi_wready <= !next_w_full;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= (state == ST_IDLE && !s_axi_rvalid && !s_axi_arready) ? 1'b1 :
                       next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

endmodule : dsc_alu_instr_subset_decode

// ==== pkg/dsc_pkg.sv ====
// Shared constants, opcodes, carriers and states for the instruction subset decoder
package dsc_pkg;
  // Register byte offsets (8-bit word-aligned address space)
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_EXINFO = 8'h0C;
  localparam logic [7:0] OFS_ACCA_LO = 8'h10;
  localparam logic [7:0] OFS_ACCA_HI = 8'h14;
  localparam logic [7:0] OFS_ACCB_LO = 8'h18;
  localparam logic [7:0] OFS_ACCB_HI = 8'h1C;
  // Region codes held in address bits 7:6
  localparam logic [1:0] RGN_MISC = 2'h0;
  localparam logic [1:0] RGN_DEFAULT_WORK_REG_ZERO = 2'h1;
  localparam logic [1:0] RGN_DMEM = 2'h2;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Instruction field positions
  localparam int OPC_LSB = 16;
  localparam int ACC_BIT = 15;
  localparam int D_BIT = 14;
  localparam int WB_LSB = 11;
  localparam int WD_LSB = 7;
  localparam int MUL_LSB = 12;
  localparam int XPF_LSB = 8;
  localparam int XD_LSB = 6;
  localparam int YPF_LSB = 2;
  // Opcodes (top eight bits of the 24-bit word)
  localparam logic [7:0] OP_SUM_WITH_CARRY_OP_F = 8'hB4;
  localparam logic [7:0] OP_SUM_WITH_CARRY_OP_L10 = 8'hB0;
  localparam logic [7:0] OP_SUM_WITH_CARRY_OP_W = 8'h48;
  localparam logic [7:0] OP_SUM_WITH_CARRY_OP_L5 = 8'h49;
  localparam logic [7:0] OP_ADD_SLIT = 8'hC9;
  localparam logic [7:0] OP_ASR_F = 8'hD5;
  localparam logic [7:0] OP_ASR_W = 8'hD1;
  localparam logic [7:0] OP_ASR_WW = 8'hDE;
  localparam logic [7:0] OP_ASR_L5 = 8'hDF;
  localparam logic [7:0] OP_BRA_C = 8'h31;
  localparam logic [7:0] OP_BRA_GE = 8'h3D;
  localparam logic [7:0] OP_BRA_GEU = 8'h3E;
  localparam logic [7:0] OP_MAC = 8'hC0;
  localparam logic [7:0] OP_SQR = 8'hC1;
  // Prefetch field special codes
  localparam logic [3:0] PF_IDX = 4'hE;
  localparam logic [3:0] PF_NONE = 4'hF;
  localparam logic [3:0] PF_SECOND = 4'h7;
  // Register numbers with fixed roles
  localparam logic [3:0] W_ZERO = 4'h0;
  localparam logic [3:0] W_MUL0 = 4'h4;
  localparam logic [3:0] W_X0 = 4'h8;
  localparam logic [3:0] W_X1 = 4'h9;
  localparam logic [3:0] W_Y0 = 4'hA;
  localparam logic [3:0] W_Y1 = 4'hB;
  localparam logic [3:0] W_IDX = 4'hC;
  // Cycle counts, reset value and accumulator saturation limits
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [39:0] ACC_MAX = 40'h7FFFFFFFFF;
  localparam logic [39:0] ACC_MIN = 40'h8000000000;
  // Status flags, c in bit 0
  typedef struct packed {
    logic sb;
    logic sa;
    logic ob;
    logic oa;
    logic dc;
    logic n;
    logic ov;
    logic z;
    logic c;
  } flags_t;
  // Execution sequencer, codes 0, 1 and 3; NOP back to IDLE changes two bits
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_NOP = 2'h3
  } fsm_t;
endpackage : dsc_pkg

// ==== tb/dsc_checker.sv ====
// Register port checker for the instruction subset decoder
module dsc_checker
  import dsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  // Read address accepted
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready && ce;
  endsequence
  // Both write channels accepted together
  sequence s_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
  endsequence
  property p_r_after_ar;
    s_ar_take |=> s_axi_rvalid;
  endproperty
  a_r_after_ar: assert property (p_r_after_ar) else $error("read data late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("second read accepted");
  property p_b_bound;
    s_w_take |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_b_bound: assert property (p_b_bound) else $error("write answer late");
  property p_r_end;
    s_axi_rvalid && s_axi_rready && ce |=> !s_axi_rvalid;
  endproperty
  a_r_end: assert property (p_r_end) else $error("read data stuck");
  property p_b_end;
    s_axi_bvalid && s_axi_bready && ce |=> !s_axi_bvalid;
  endproperty
  a_b_end: assert property (p_b_end) else $error("write answer stuck");
  property p_b_code;
    s_axi_bvalid |-> (s_axi_bresp == RESP_OKAY) || (s_axi_bresp == RESP_SLVERR);
  endproperty
  a_b_code: assert property (p_b_code) else $error("bad write response");
endmodule : dsc_checker

bind dsc_alu_instr_subset_decode dsc_checker dsc_checker_inst (.aclk, .aresetn, .ce,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready);

// ==== tb/testbench.sv ====
// Self-checking bench for the instruction subset decoder
module testbench
  import dsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
  `define CK(a, e) begin rd(a, d, r); `CHK(d, e) end
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  dsc_alu_instr_subset_decode dsc_alu_instr_subset_decode_inst (.aclk, .aresetn, .ce,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  // 40 MHz clock
  always #12.5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic conclude();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  // Hang guard
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      conclude();
    end
  end
  // Bus write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ad;
    logic dd;
    @(posedge aclk);
    ad = 1'b0;
    dd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge aclk);
      if (!ad && s_axi_awready)
      begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dd && s_axi_wready)
      begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // Bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // Work register write
  task automatic ww(input logic [3:0] n, input logic [15:0] v);
    wr({RGN_DEFAULT_WORK_REG_ZERO, n, 2'h0}, {16'h0, v}, r);
  endtask : ww
  // Issue one instruction, wait for idle, check its cycle count
  task automatic run(input logic [23:0] ins, input logic [1:0] cyc);
    wr(OFS_INSTR, {8'h00, ins}, r);
    d = 32'h4;
    for (int i = 0; i < 10 && d[2]; i++)
      rd(OFS_EXINFO, d, r);
    `CHK(d[1:0], cyc)
  endtask : run
  ////////////////////////////////////////////////////////////////
  // High register select and unmapped read
  task automatic t_regs();
    ww(4'hF, 16'hA5A5);
    `CK({RGN_DEFAULT_WORK_REG_ZERO, 4'hF, 2'h0}, 32'hA5A5)
    rd(8'h30, d, r);
    `CHK(r, RESP_SLVERR)
  endtask : t_regs
  // Sums with carry: literal, short literal, file into W0
  task automatic t_sum();
    ww(4'h3, 16'h0010);
    wr(OFS_STATUS, 32'h083, r);
    run(24'hB03FF3, CYC_ONE);
    `CK({RGN_DEFAULT_WORK_REG_ZERO, 4'h3, 2'h0}, 32'h0410)
    `CK(OFS_STATUS, 32'h090)
    ww(4'h1, 16'h7FFF);
    wr(OFS_STATUS, 32'h001, r);
    run(24'h49091F, CYC_ONE);
    `CK({RGN_DEFAULT_WORK_REG_ZERO, 4'h2, 2'h0}, 32'h801F)
    `CK(OFS_STATUS, 32'h01C)
    wr(8'h88, 32'hFFFF, r);
    ww(4'h0, 16'h0001);
    wr(OFS_STATUS, 32'h002, r);
    run(24'hB40004, CYC_ONE);
    `CK({RGN_DEFAULT_WORK_REG_ZERO, 4'h0, 2'h0}, 32'h0)
    `CK(OFS_STATUS, 32'h013)
    `CK(8'h88, 32'hFFFF)
  endtask : t_sum
  // Sign-filling shifts by one, by literal, by register
  task automatic t_shift();
    ww(4'h1, 16'h8001);
    wr(OFS_STATUS, 32'h004, r);
    run(24'hD10101, CYC_ONE);
    `CK({RGN_DEFAULT_WORK_REG_ZERO, 4'h2, 2'h0}, 32'hC000)
    `CK(OFS_STATUS, 32'h009)
    wr(OFS_STATUS, 32'h005, r);
    run(24'hDF0904, CYC_ONE);
    `CK({RGN_DEFAULT_WORK_REG_ZERO, 4'h2, 2'h0}, 32'hF800)
    `CK(OFS_STATUS, 32'h00D)
    ww(4'h3, 16'h000F);
    run(24'hDE0903, CYC_ONE);
    `CK({RGN_DEFAULT_WORK_REG_ZERO, 4'h2, 2'h0}, 32'hFFFF)
    `CK(OFS_STATUS, 32'h00D)
  endtask : t_shift
  // Signed literal added into each accumulator
  task automatic t_acc();
    ww(4'h1, 16'h8000);
    run(24'hC90781, CYC_ONE);
    `CK(OFS_ACCA_LO, 32'hFFFF7FFF)
    `CK(OFS_ACCA_HI, 32'h00FF)
    run(24'hC98781, CYC_ONE);
    `CK(OFS_ACCB_LO, 32'hFFFF7FFF)
  endtask : t_acc
  // Signed and unsigned jumps, taken and not taken
  task automatic t_jump();
    logic [7:0] ops [4] = '{OP_BRA_GE, OP_BRA_GE, OP_BRA_GEU, OP_BRA_GEU};
    logic [31:0] sts [4] = '{32'h180, 32'h188, 32'h181, 32'h180};
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_PC, 32'h0010, r);
      wr(OFS_STATUS, sts[i], r);
      run({ops[i], 16'h0005}, (i % 2 == 0) ? CYC_TWO : CYC_ONE);
      `CK(OFS_PC, (i % 2 == 0) ? 32'h0016 : 32'h0011)
      `CK(OFS_STATUS, sts[i])
    end
  endtask : t_jump
  // Multiply accumulate with prefetch, square accumulate without, then an illegal pair
  task automatic t_mac();
    ww(4'h4, 16'h0003);
    ww(4'h5, 16'h0002);
    ww(4'h7, 16'h0004);
    ww(4'h8, 16'h0006);
    wr(8'h8C, 32'h1234, r);
    run(24'hC001A5, CYC_ONE);
    `CK(OFS_ACCA_LO, 32'hFFFF8005)
    `CK({RGN_DEFAULT_WORK_REG_ZERO, 4'h6, 2'h0}, 32'h1234)
    `CK({RGN_DEFAULT_WORK_REG_ZERO, 4'h8, 2'h0}, 32'h0008)
    `CK({RGN_DEFAULT_WORK_REG_ZERO, 4'h5, 2'h0}, 32'h0000)
    `CK({RGN_DEFAULT_WORK_REG_ZERO, 4'hB, 2'h0}, 32'h0004)
    run(24'hC1BF3C, CYC_ONE);
    `CK(OFS_ACCB_LO, 32'hFFFF800F)
    run(24'hC06000, CYC_ONE);
    `CK(OFS_EXINFO, 32'h0009)
  endtask : t_mac
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_sum();
    t_shift();
    t_acc();
    t_jump();
    t_mac();
    conclude();
  end
endmodule : testbench
